// ### logic/pic_cfg.svh
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Control word offsets in the bit-addressable RAM area
`define PIC_WORD0        10'h000
`define PIC_WORD1        10'h001
`define PIC_WORD2        10'h002
`define PIC_WORD3        10'h003

// Source count and layout of flag and mask bits
`define PIC_NUM_SRC      7
`define PIC_IE_BIT       0
`define PIC_IE_WORD      0
`define PIC_FLAG_WORD(i) (((i) + 1) / 2)
`define PIC_FLAG_BIT(i)  ((((i) + 1) % 2) * 2)
`define PIC_MASK_OFS     1

// Reset values
`define PIC_RST_IE       1'b0
`define PIC_RST_FLAGS    7'h00
`define PIC_RST_MASKS    7'h7F

// Vector table
`define PIC_VEC_START    16'h0000
`define PIC_VEC_STEP     16'h0002

`endif

// ### logic/pic_pkg.sv
package pic_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FINISH,
      ST_PUSH_A,
      ST_PUSH_B
   } pic_state_t;

   // Answer to the CPU sequencer
   typedef struct packed {
      logic        disableIe;
      logic        push;
      logic        jump;
      logic [15:0] vector;
   } pic_cpu_t;

   // Register access from the RAM bit-manipulation path
   typedef struct packed {
      logic       rdEn;
      logic       wrEn;
      logic [9:0] addr;
      logic [3:0] wrData;
      logic [3:0] wrMask;
   } pic_ram_t;

endpackage

// ### logic/pic_pin_sync.sv
`timescale 1ns/1ps
module pic_pin_sync
   import pic_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Pins and edges
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinLevel,
   output logic      [WIDTH-1:0] riseEdge,
   output logic      [WIDTH-1:0] fallEdge
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;

   // Only sync_q reads meta_q; edges come from later stages
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end
      else
      begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign pinLevel = sync_q;
   assign riseEdge = sync_q & ~last_q;
   assign fallEdge = ~sync_q & last_q;
endmodule // pic_pin_sync

// ### logic/pic_prio_enc.sv
`timescale 1ns/1ps
module pic_prio_enc
   import pic_pkg::*;
#(
   parameter int N = 7
)
(
   // Requests, index 0 highest
   input  wire logic [N-1:0]         req,
   output logic                      any,
   output logic      [$clog2(N)-1:0] idx
);
   function automatic logic [$clog2(N)-1:0] firstSet(input logic [N-1:0] v);
      logic [$clog2(N)-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--)
         if (v[i])
            r = i[$clog2(N)-1:0];
      return r;
   endfunction

   assign any = |req;
   assign idx = firstSet(req);
endmodule // pic_prio_enc

// ### logic/pic_irq_ctrl.sv
`timescale 1ns/1ps
`include "pic_cfg.svh"
// Behaviour
// - Fixed priority ext0..serial, vectors 0002..000E; reset and stop-cancel use 0000.
// - Stop-cancel pin requests start vector only in stop mode, ignored otherwise.
// - Take source if enable, flag set, mask clear, no higher unmasked flag.
// - Global enable is word 0 bit 0; 0 blocks, 1 allows interrupts.
// - Accept clears global enable; return-from-interrupt sets it again.
// - Rising edge of ext pin 0 sets word0 bit2; pin 1 sets word1 bit0.
// - Ext masks at word0 bit3 and word1 bit1; 1 blocks, 0 passes.
// - Timer A overflow sets word1 bit2; mask word1 bit3.
// - Timer B overflow sets word2 bit0; mask word2 bit1.
// - Timer C overflow sets word2 bit2; mask word2 bit3.
// - Serial end or suspend sets word3 bit2; mask word3 bit3.
// - Conversion done sets word3 bit0; mask word3 bit1.
// - Reset clears enable and flags, sets all masks.
// - Software writes cannot set a flag; only hardware events do.
// - Accept: finish instruction, clear enable and push, push and jump to vector.
module pic_irq_ctrl
   import pic_pkg::*;
#(
   parameter int NSRC = `PIC_NUM_SRC
)
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Pins
   input  wire logic        extIrqPin0,
   input  wire logic        extIrqPin1,
   input  wire logic        stopCancelPin_n,
   // Peripheral events, one-cycle pulses
   input  wire logic        timerAOvf,
   input  wire logic        timerBOvf,
   input  wire logic        timerCOvf,
   input  wire logic        conversionDone,
   input  wire logic        serialDone,
   // CPU status
   input  wire logic        instrEnd,
   input  wire logic        returnFromIrq,
   input  wire logic        stopMode,
   // RAM bit access
   input  wire pic_ram_t    ram,
   output logic      [3:0]  ramRdData_q,
   // CPU sequencer
   output pic_cpu_t         cpu_q,
   output logic             irqPending_q,
   output logic             stopWake_q
);
   typedef logic [3:0] word_t;

   logic [NSRC-1:0] flag_q;
   logic [NSRC-1:0] flag_d;
   logic [NSRC-1:0] mask_q;
   logic [NSRC-1:0] mask_d;
   logic            ie_q;
   logic            ie_d;
   pic_state_t      state_q;
   pic_state_t      state_d;
   logic [15:0]     vecHold_q;

   wire logic [2:0]      pinRise;
   wire logic [2:0]      pinFall;
   wire logic [NSRC-1:0] srcEvent;
   wire logic [NSRC-1:0] active;
   wire logic            anyActive;
   wire logic [2:0]      winIdx;
   wire logic            accept;
   wire logic            wrSel [4];
   wire word_t           rdWord [4];
   wire logic [15:0]     winVector;

   function automatic logic wordHit(input logic [9:0] a, input logic [9:0] w);
      return a == w;
   endfunction

   pic_pin_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pinIn    ({stopCancelPin_n, extIrqPin1, extIrqPin0}),
      .pinLevel (),
      .riseEdge (pinRise),
      .fallEdge (pinFall)
   );

   assign srcEvent = {serialDone, conversionDone, timerCOvf, timerBOvf,
                      timerAOvf, pinRise[1], pinRise[0]};

   // Write decode per word
   assign wrSel[0] = ram.wrEn & wordHit(ram.addr, `PIC_WORD0);
   assign wrSel[1] = ram.wrEn & wordHit(ram.addr, `PIC_WORD1);
   assign wrSel[2] = ram.wrEn & wordHit(ram.addr, `PIC_WORD2);
   assign wrSel[3] = ram.wrEn & wordHit(ram.addr, `PIC_WORD3);

   // Flags and masks, one slice per source
   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : g_src
         localparam int W = `PIC_FLAG_WORD(g);
         localparam int B = `PIC_FLAG_BIT(g);
         wire logic flagWr = wrSel[W] & ram.wrMask[B];
         wire logic maskWr = wrSel[W] & ram.wrMask[B + `PIC_MASK_OFS];
         // Writes can only clear; the event wins over a clear
         assign flag_d[g] = srcEvent[g] | (flag_q[g] & ~(flagWr & ~ram.wrData[B]));
         assign mask_d[g] = maskWr ? ram.wrData[B + `PIC_MASK_OFS] : mask_q[g];
      end
   endgenerate

   assign active = flag_q & ~mask_q;

   pic_prio_enc #(.N(NSRC)) u_prio (
      .req (active),
      .any (anyActive),
      .idx (winIdx)
   );

   assign winVector = `PIC_VEC_STEP + `PIC_VEC_STEP * {13'h0000, winIdx};
   assign accept    = (state_q == ST_IDLE) & instrEnd & ie_q & anyActive;

   // Enable: accept clears in the ST_FINISH step, return sets it
   assign ie_d = (state_q == ST_FINISH) ? 1'b0 :
                 returnFromIrq          ? 1'b1 :
                 (wrSel[`PIC_IE_WORD] & ram.wrMask[`PIC_IE_BIT]) ? ram.wrData[`PIC_IE_BIT] :
                 ie_q;

   // Read words; unused bit 1 of word 0 reads as zero
   assign rdWord[0] = {mask_q[0], flag_q[0], 1'b0, ie_q};
   assign rdWord[1] = {mask_q[2], flag_q[2], mask_q[1], flag_q[1]};
   assign rdWord[2] = {mask_q[4], flag_q[4], mask_q[3], flag_q[3]};
   assign rdWord[3] = {mask_q[6], flag_q[6], mask_q[5], flag_q[5]};

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (accept) state_d = ST_FINISH;
         ST_FINISH: state_d = ST_PUSH_A;
         ST_PUSH_A: state_d = ST_PUSH_B;
         ST_PUSH_B: state_d = ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q  <= `PIC_RST_FLAGS;
         mask_q  <= `PIC_RST_MASKS;
         ie_q    <= `PIC_RST_IE;
         state_q <= ST_IDLE;
      end
      else
      begin
         flag_q  <= flag_d;
         mask_q  <= mask_d;
         ie_q    <= ie_d;
         state_q <= state_d;
      end
   end

   // Vector is frozen at accept so later flag changes cannot redirect the jump
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         vecHold_q <= `PIC_VEC_START;
      else if (accept)
         vecHold_q <= winVector;
   end

   // CPU answer, all outputs registered
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpu_q        <= '0;
         irqPending_q <= 1'b0;
         stopWake_q   <= 1'b0;
         ramRdData_q  <= '0;
      end
      else
      begin
         cpu_q.disableIe <= (state_q == ST_FINISH);
         cpu_q.push      <= (state_q == ST_FINISH) | (state_q == ST_PUSH_A);
         cpu_q.jump      <= (state_q == ST_PUSH_A) | (stopMode & pinFall[2]);
         cpu_q.vector    <= (stopMode & pinFall[2]) ? `PIC_VEC_START : vecHold_q;
         irqPending_q    <= ie_q & anyActive;
         stopWake_q      <= stopMode & pinFall[2];
         ramRdData_q     <= ram.rdEn ? rdWord[ram.addr[1:0]] & {4{ram.addr[9:2] == 8'h00}} : 4'h0;
      end
   end

   // Checks
   sequence acceptSeq;
      accept ##1 (state_q == ST_FINISH);
   endsequence

   sequence pushSeq;
      cpu_q.push && cpu_q.disableIe && !ie_q ##1 cpu_q.push && !cpu_q.disableIe && cpu_q.jump;
   endsequence

   accept_sequence_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      acceptSeq |=> pushSeq) else $error("interrupt accept sequence broken");

   accept_clears_ie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept |-> ##2 !ie_q) else $error("enable not cleared after accept");

   return_from_irq_instr_sets_ie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      returnFromIrq && state_q != ST_FINISH |=> ie_q) else $error("return did not set enable");

   ie_blocks_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !ie_q |-> !accept) else $error("accept while enable clear");

   priority_vector_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && active[0] |-> ##3 cpu_q.jump && cpu_q.vector == 16'h0002)
      else $error("highest source vector wrong");

   lowest_vector_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && active == 7'h40 |-> ##3 cpu_q.vector == 16'h000E) else $error("serial vector wrong");

   no_sw_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !flag_q[3] && !srcEvent[3] |=> !flag_q[3]) else $error("flag set without event");

   set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      srcEvent[6] |=> flag_q[6]) else $error("event lost against clear");

   ext_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(extIrqPin0) |-> ##3 flag_q[0]) else $error("ext pin 0 edge not flagged");

   stop_cancel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      stopWake_q |-> $past(stopMode) && cpu_q.vector == 16'h0000) else $error("stop wake outside stop");

   mask_blocks_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      mask_q[1] && !(|active[0]) && active[6:2] == 5'h00 |-> !accept) else $error("masked source taken");
endmodule // pic_irq_ctrl

// ### verif/pic_cpu_model.sv
`timescale 1ns/1ps
module pic_cpu_model
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic     core_clk,
   input  wire logic     rst_n,
   // Sequencer view
   input  wire pic_cpu_t cpu,
   input  wire logic     slow,
   output logic          instrEnd,
   output logic          returnFromIrq
);
   int rtniCnt = 0;
   initial instrEnd = 1'b0;
   initial returnFromIrq = 1'b0;
   // Slow core reaches a boundary only every other cycle
   always @(negedge core_clk)
   begin
      instrEnd <= rst_n && (!slow || !instrEnd);
      // Handler returns late, after software has cleared its flag
      returnFromIrq <= (rtniCnt == 1);
      rtniCnt <= (cpu.jump && cpu.vector != 16'h0000) ? 16 : (rtniCnt > 0 ? rtniCnt - 1 : 0);
   end
endmodule // pic_cpu_model

// ### verif/pic_irq_ctrl_tb.sv
`timescale 1ns/1ps
module pic_irq_ctrl_tb
   import pic_pkg::*;
;
   logic          core_clk;
   logic          rst_n;
   logic [6:0]    ev;
   logic          stopCancelPin_n;
   logic          stopMode;
   logic          slow;
   logic          instrEnd;
   logic          returnFromIrq;
   logic          rdSeen = 1'b0;
   pic_ram_t      ram;
   logic [3:0]    ramRdData_q;
   pic_cpu_t      cpu_q;
   logic          irqPending_q;
   logic          stopWake_q;
   logic [15:0]   rdQ[$];
   logic [15:0]   vecQ[$];
   logic [6:0]    fl;
   logic [6:0]    mk;
   int            err_count = 0;
   int            samples_checked = 0;
   int            jumps = 0;
   int            wakes = 0;
   int            seed = 84568;
   int            i;
   int            k;
   int            exp;

   pic_irq_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .extIrqPin0(ev[0]), .extIrqPin1(ev[1]),
      .stopCancelPin_n(stopCancelPin_n), .timerAOvf(ev[2]), .timerBOvf(ev[3]), .timerCOvf(ev[4]),
      .conversionDone(ev[5]), .serialDone(ev[6]), .instrEnd(instrEnd), .returnFromIrq(returnFromIrq),
      .stopMode(stopMode), .ram(ram), .ramRdData_q(ramRdData_q), .cpu_q(cpu_q),
      .irqPending_q(irqPending_q), .stopWake_q(stopWake_q));
   pic_cpu_model u_cpu (.core_clk(core_clk), .rst_n(rst_n), .cpu(cpu_q), .slow(slow),
      .instrEnd(instrEnd), .returnFromIrq(returnFromIrq));

   function automatic int fwd(int s);
      return (s + 1) / 2;
   endfunction
   function automatic int fbt(int s);
      return ((s + 1) % 2) * 2;
   endfunction

   task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic acc(input logic rd, input int a, input logic [3:0] d, input logic [3:0] m);
      @(negedge core_clk);
      ram = '{rdEn: rd, wrEn: !rd, addr: 10'(a), wrData: d, wrMask: m};
      @(negedge core_clk);
      ram = '0;
   endtask
   task automatic rd(input int a, input logic [3:0] e);
      rdQ.push_back({12'h000, e});
      acc(1'b1, a, 4'h0, 4'h0);
   endtask
   task automatic wr(input int a, input logic [3:0] d, input logic [3:0] m);
      acc(1'b0, a, d, m);
   endtask
   task automatic fire(input logic [6:0] v);
      @(negedge core_clk);
      ev = v;
      @(negedge core_clk);
      ev = '0;
      repeat (5) @(negedge core_clk);
   endtask
   task automatic waitJ();
      int n;
      n = jumps;
      for (int j = 0; j < 40 && jumps == n; j++) @(negedge core_clk);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Reads answer one edge after rdEn; outputs settle before the falling edge
   always @(posedge core_clk) rdSeen <= ram.rdEn;
   always @(negedge core_clk)
   begin
      if (rdSeen) check("rdData", rdQ.pop_front(), {12'h000, ramRdData_q});
      if (rst_n && cpu_q.jump === 1'b1)
      begin
         jumps++;
         check("vector", vecQ.size() ? vecQ.pop_front() : 16'hDEAD, cpu_q.vector);
      end
      if (stopWake_q === 1'b1) wakes++;
   end
   initial
   begin
      #100us;
      err_count++;
      print_verdict();
   end

   initial
   begin
      ram = '0;
      ev = '0;
      stopCancelPin_n = 1'b1;
      stopMode = 1'b0;
      slow = 1'b0;
      rst_n = 1'b0;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      for (i = 0; i < 5; i++) rd(i, i == 0 ? 4'h8 : (i < 4 ? 4'hA : 4'h0));
      wr(1, 4'hF, 4'hF);
      rd(1, 4'hA);
      for (i = 0; i < 7; i++)
      begin
         slow = 1'($random(seed));
         wr(fwd(i), 4'h0, 4'b1 << (fbt(i) + 1));
         fire(7'b1 << i);
         rd(fwd(i), ((fwd(i) == 0) ? 4'h8 : 4'hA) & ~(4'b1 << (fbt(i) + 1)) | (4'b1 << fbt(i)));
         check("irqPending", 16'h0000, {15'h0000, irqPending_q});
         vecQ.push_back(16'(2 + 2 * i));
         wr(0, 4'h1, 4'h1);
         @(negedge core_clk);
         check("irqPending", 16'h0001, {15'h0000, irqPending_q});
         waitJ();
         wr(fwd(i), 4'b1 << (fbt(i) + 1), 4'b11 << fbt(i));
         repeat (20) @(negedge core_clk);
         rd(0, 4'h9);
         wr(0, 4'h0, 4'h1);
      end
      for (i = 0; i < 6; i++)
      begin
         fl = 7'($random(seed));
         mk = 7'($random(seed));
         fl[i] = 1'b1;
         mk[i] = 1'b0;
         for (k = 0; k < 7; k++) wr(fwd(k), 4'(mk[k]) << (fbt(k) + 1), 4'b1 << (fbt(k) + 1));
         fire(fl);
         exp = 7;
         for (k = 6; k >= 0; k--) if (fl[k] && !mk[k]) exp = k;
         vecQ.push_back(16'(2 + 2 * exp));
         wr(0, 4'h1, 4'h1);
         waitJ();
         wr(0, 4'h0, 4'h4);
         for (k = 1; k < 4; k++) wr(k, 4'h0, 4'h5);
         repeat (20) @(negedge core_clk);
         wr(0, 4'h0, 4'h1);
      end
      wr(2, 4'hA, 4'hA);
      @(negedge core_clk);
      ev[3] = 1'b1;
      ram = '{rdEn: 1'b0, wrEn: 1'b1, addr: 10'h002, wrData: 4'h0, wrMask: 4'h1};
      @(negedge core_clk);
      ev = '0;
      ram = '0;
      rd(2, 4'hB);
      for (k = 0; k < 2; k++)
      begin
         stopMode = 1'(k);
         if (k == 1) vecQ.push_back(16'h0000);
         stopCancelPin_n = 1'b0;
         repeat (6) @(negedge core_clk);
         stopCancelPin_n = 1'b1;
         repeat (6) @(negedge core_clk);
      end
      check("wakes", 16'h0001, 16'(wakes));
      check("pending", 16'h0000, 16'(vecQ.size()));
      print_verdict();
   end
endmodule // pic_irq_ctrl_tb
